// File: irqbt_pkg.sv
// constants, register map and types for the interrupt flag and base timer block
// Behaviour
// RL1 - capture flag set on byte/end, service clears
// RL2 - write zero clears flag, one keeps
// RL3 - timer overflows set flags, service clears
// RL4 - external pin edge sets flag, service clears
// RL5 - bad fetch or idle sets function flag
// RL6 - nak, ack, stall events set summary flag
// RL7 - endpoint zero out done sets flag
// RL8 - endpoint zero in done, service clears
// RL9 - wrong toggle out sets error flag
// RL10 - setup overwrite noted, flagged on next token
// RL11 - setup done sets flag, service clears
// RL12 - endpoint one/two in done flags, software clear
// RL13 - stall answers set rx/tx stall flags
// RL14 - separate nak flag per endpoint case
// RL15 - bus idle over 5 ms sets suspend
// RL16 - bad fetch address sets flag, software clear
// RL17 - any reset clears flags and timers
// RL18 - 8-bit readable counters, reset disabled, cleared
// RL19 - count to FF, wrap, flag, reload preset
// RL20 - preset write while counting loads at once
// RL21 - enable level counts, rising edge restarts
// RL22 - prescale divides base rate by 2^n
// RL23 - edge select: zero falling, one rising
// RL24 - service acknowledge clears hardware-clearable flags
package irqbt_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_EXT_EDGE = 8'hBD;
  localparam logic [7:0] IDX_T0_PRESET = 8'hD2;
  localparam logic [7:0] IDX_T1_PRESET = 8'hD3;
  localparam logic [7:0] IDX_TMR_CTRL = 8'hD4;
  localparam logic [7:0] IDX_FLAGS_CORE = 8'hDA;
  localparam logic [7:0] IDX_FLAGS_MAIN = 8'hDB;
  localparam logic [7:0] IDX_FLAGS_HS = 8'hDE;
  localparam logic [7:0] IDX_FLAGS_FUN = 8'hDF;
  // core flag bits
  localparam int B_EXT_PIN_IRQ_FLAG = 0;
  localparam int B_T0_OVF = 1;
  localparam int B_T1_OVF = 3;
  localparam int B_CAPTURE = 4;
  // main usb flag bits
  localparam int B_SETUP = 0;
  localparam int B_SETUP_OVW = 1;
  localparam int B_TOGGLE_ERR = 2;
  localparam int B_EP0_IN = 3;
  localparam int B_EP0_OUT = 4;
  localparam int B_SUMMARY = 5;
  localparam int B_FUNCTION = 6;
  // handshake flag bits
  localparam int B_NAK_EP0_IN = 0;
  localparam int B_NAK_EP0_OUT = 1;
  localparam int B_NAK_EP1_IN = 2;
  localparam int B_NAK_EP2_IN = 3;
  localparam int B_STALL_TX = 4;
  localparam int B_STALL_RX = 5;
  localparam int B_EP1_IN = 6;
  localparam int B_EP2_IN = 7;
  // function flag bits
  localparam int B_BAD_FETCH = 1;
  localparam int B_BUS_IDLE = 2;
  // implemented bits and hardware-clearable bits
  localparam logic [7:0] MASK_CORE = 8'h1B;
  localparam logic [7:0] MASK_MAIN = 8'h7F;
  localparam logic [7:0] MASK_HS = 8'hFF;
  localparam logic [7:0] MASK_FUN = 8'h06;
  localparam logic [7:0] MASK_EDGE = 8'h01;
  localparam logic [7:0] HWCLR_CORE = 8'h1B;
  localparam logic [7:0] HWCLR_MAIN = 8'h0F;
  // timer control fields
  localparam int TC_T0_PRE_LSB = 0;
  localparam int TC_T0_RUN = 3;
  localparam int TC_T1_PRE_LSB = 4;
  localparam int TC_T1_RUN = 7;
  localparam int PRE_W = 3;
  // base rate is the system clock divided by this
  localparam int BASE_DIV = 12;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // bus slave states, one-hot
  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0001,
    BUS_WRITE = 4'b0010,
    BUS_RWAIT = 4'b0100,
    BUS_RDATA = 4'b1000
  } irqbt_bus_t;
endpackage : irqbt_pkg

// File: irqbt_timer.sv
// one 8-bit auto-reload base timer with prescaler
`timescale 1ns/10ps
module irqbt_timer #(
  parameter int W = 8,
  parameter int PW = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clr,
  // control
  input wire logic run,
  input wire logic [PW-1:0] prescale,
  input wire logic [W-1:0] preset,
  input wire logic preset_wr,
  input wire logic [W-1:0] wdata,
  input wire logic base_tick,
  // state
  output logic [W-1:0] count,
  output logic ovf
);
  localparam int PC_W = (1 << PW) - 1;
  localparam logic [W-1:0] CNT_MAX = {W{1'b1}};

  if (W < 2 || PW < 1 || PW > 5)
  begin : g_bad
    $error("irqbt_timer: unsupported width");
  end

  logic run_q; // last enable level, for edge detect
  logic [PC_W-1:0] pre_cnt; // prescale divider
  logic [PC_W-1:0] pre_mask; // low bits that must be all ones
  logic rise; // enable just went high
  logic tick; // one count step

  assign rise = run & ~run_q;
  assign pre_mask = PC_W'((1 << prescale) - 1);
  // divide base rate by two to the field value
  assign tick = run & base_tick & ((pre_cnt & pre_mask) == pre_mask); // see RL22

  // enable edge tracker
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      run_q <= 1'b0;
    else if (clr)
      run_q <= 1'b0;
    else
      run_q <= run;
  end

  // prescaler restarts with every rising enable edge
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pre_cnt <= '0;
    else if (clr || rise)
      pre_cnt <= '0; // see RL21
    else if (run && base_tick)
      pre_cnt <= pre_cnt + 1'b1; // see RL22
  end

  // counter; disabled timer holds its value
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0; // see RL18
    else if (clr)
      count <= '0; // see RL17
    else if (rise)
      count <= preset; // see RL21
    else if (run && preset_wr)
      count <= wdata; // see RL20
    else if (tick)
      count <= (count == CNT_MAX) ? preset : count + 1'b1; // see RL19
  end

  // overflow pulse, one cycle per wrap
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ovf <= 1'b0;
    else
      ovf <= ~clr & ~rise & ~preset_wr & tick & (count == CNT_MAX); // see RL19
  end

  AST_TMR_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && run_q && preset_wr && !clr |=> count == $past(wdata)) // see RL20
    else $error("preset write not loaded");
  AST_TMR_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rise && !clr |=> count == $past(preset)) // see RL21
    else $error("enable edge did not restart");
endmodule : irqbt_timer

// File: irqbt_top.sv
// interrupt flag registers and two base timers behind an ahb-lite slave
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
module irqbt_top
  import irqbt_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // usb engine events, one-cycle pulses
  input wire logic usb_reset,
  input wire logic ev_capture_done,
  input wire logic ev_ep0_out_done,
  input wire logic ev_ep0_in_done,
  input wire logic ev_ep0_toggle_err,
  input wire logic ev_setup_overwrite,
  input wire logic ev_setup_done,
  input wire logic ev_token_inout,
  input wire logic ev_ep1_in_done,
  input wire logic ev_ep2_in_done,
  input wire logic ev_ep0_rx_stall,
  input wire logic ev_ep0_tx_stall,
  input wire logic ev_ep2_in_nak,
  input wire logic ev_ep1_in_nak,
  input wire logic ev_ep0_out_nak,
  input wire logic ev_ep0_in_nak,
  input wire logic ev_ep1_in_ack,
  input wire logic ev_ep2_in_ack,
  input wire logic ev_bus_idle,
  input wire logic ev_bad_fetch,
  // external interrupt pin
  input wire logic ext_irq_pin,
  // cpu service acknowledge, one bit per flag
  input wire logic [7:0] ack_core,
  input wire logic [7:0] ack_main,
  // flag levels to the cpu interrupt logic
  output logic [7:0] irq_flags_core,
  output logic [7:0] irq_flags_usb_main,
  output logic [7:0] irq_flags_usb_handshake,
  output logic [7:0] irq_flags_usb_function
);
  import irqbt_pkg::*;

  // reset release
  logic rst_q1; // first reset stage
  logic rst_n; // synchronised reset
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // write-zero clear mask for one register
  function automatic logic [7:0] w0_mask(input logic wr, input logic [7:0] idx,
                                         input logic [7:0] reg_idx,
                                         input logic [7:0] wb);
    w0_mask = (wr && idx == reg_idx) ? ~wb : ZERO_BYTE;
  endfunction : w0_mask

  // bus slave state
  irqbt_bus_t state; // current bus phase
  irqbt_bus_t next_state; // following phase
  logic accept; // address phase taken this edge
  logic [7:0] addr_idx; // register index of the transfer
  logic wr_now; // write data phase, hwdata valid
  logic [7:0] wbyte; // written byte

  assign accept = hsel & hready & htrans[1] & (state != BUS_RWAIT);
  assign wr_now = (state == BUS_WRITE);
  assign wbyte = hwdata[7:0];
  assign hreadyout = (state != BUS_RWAIT); // reads insert one wait
  assign hresp = 1'b0; // always okay

  // next bus phase
  always_comb
  begin
    next_state = state;
    case (state)
      BUS_RWAIT: next_state = BUS_RDATA;
      default:
      begin
        if (!accept)
          next_state = BUS_IDLE;
        else if (hwrite)
          next_state = BUS_WRITE;
        else
          next_state = BUS_RWAIT;
      end
    endcase
  end

  // bus state and captured index
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= BUS_IDLE;
      addr_idx <= ZERO_BYTE;
    end
    else
    begin
      state <= next_state;
      if (accept)
        addr_idx <= haddr[9:2]; // word index, byte lanes unused
    end
  end

  // control registers
  logic [7:0] t0_preset; // timer zero preset
  logic [7:0] t1_preset; // timer one preset
  logic [7:0] timer_control; // run and prescale fields
  logic ext_edge_select; // 0 falling, 1 rising
  logic [7:0] t0_count; // live timer zero count
  logic [7:0] t1_count; // live timer one count
  logic t0_ovf; // timer zero wrap pulse
  logic t1_ovf; // timer one wrap pulse

  // preset and control writes; usb reset clears like hardware reset
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      t0_preset <= ZERO_BYTE;
      t1_preset <= ZERO_BYTE;
      timer_control <= ZERO_BYTE;
    end
    else if (usb_reset)
    begin
      t0_preset <= ZERO_BYTE; // see RL17
      t1_preset <= ZERO_BYTE;
      timer_control <= ZERO_BYTE;
    end
    else if (wr_now)
    begin
      if (addr_idx == IDX_T0_PRESET)
        t0_preset <= wbyte;
      else if (addr_idx == IDX_T1_PRESET)
        t1_preset <= wbyte;
      else if (addr_idx == IDX_TMR_CTRL)
        timer_control <= wbyte;
    end
  end

  // edge select is reset by hardware reset only
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ext_edge_select <= 1'b0;
    else if (wr_now && addr_idx == IDX_EXT_EDGE)
      ext_edge_select <= wbyte[0];
  end

  // base rate: system clock divided by twelve
  logic [3:0] base_div; // divide counter
  logic base_tick; // one pulse per base period
  assign base_tick = (base_div == 4'(BASE_DIV - 1)); // see RL22
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      base_div <= 4'h0;
    else if (base_tick || usb_reset)
      base_div <= 4'h0;
    else
      base_div <= base_div + 4'h1;
  end

  // timer zero
  irqbt_timer #(.W(8), .PW(PRE_W)) u_timer0 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(usb_reset),
    .run(timer_control[TC_T0_RUN]),
    .prescale(timer_control[TC_T0_PRE_LSB +: PRE_W]),
    .preset(t0_preset),
    .preset_wr(wr_now && addr_idx == IDX_T0_PRESET),
    .wdata(wbyte),
    .base_tick(base_tick),
    .count(t0_count),
    .ovf(t0_ovf)
  );

  // timer one
  irqbt_timer #(.W(8), .PW(PRE_W)) u_timer1 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(usb_reset),
    .run(timer_control[TC_T1_RUN]),
    .prescale(timer_control[TC_T1_PRE_LSB +: PRE_W]),
    .preset(t1_preset),
    .preset_wr(wr_now && addr_idx == IDX_T1_PRESET),
    .wdata(wbyte),
    .base_tick(base_tick),
    .count(t1_count),
    .ovf(t1_ovf)
  );

  // external pin synchroniser and edge detect
  logic ext_s1; // first stage, read only by the second
  logic ext_s2; // synchronised level
  logic ext_s3; // previous level
  logic ext_edge; // selected edge seen
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      ext_s3 <= 1'b1;
    end
    else
    begin
      ext_s1 <= ext_irq_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end
  assign ext_edge = ext_edge_select ? (ext_s2 & ~ext_s3) : (~ext_s2 & ext_s3); // see RL23

  // setup overwrite noted until the next in or out token
  logic setup_overwrite_latch; // setup overwrote unread data
  logic ovw_fire; // token after overwritten setup
  assign ovw_fire = setup_overwrite_latch & ev_token_inout; // see RL10
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      setup_overwrite_latch <= 1'b0;
    else if (usb_reset)
      setup_overwrite_latch <= 1'b0;
    else if (ev_setup_overwrite)
      setup_overwrite_latch <= 1'b1; // see RL10
    else if (ovw_fire)
      setup_overwrite_latch <= 1'b0;
  end

  // hardware set vectors
  logic [7:0] set_core; // core flag sets
  logic [7:0] set_main; // main usb flag sets
  logic [7:0] set_hs; // handshake flag sets
  logic [7:0] set_fun; // function flag sets
  always_comb
  begin
    set_core = ZERO_BYTE;
    set_main = ZERO_BYTE;
    set_hs = ZERO_BYTE;
    set_fun = ZERO_BYTE;
    set_core[B_CAPTURE] = ev_capture_done; // see RL1
    set_core[B_T1_OVF] = t1_ovf; // see RL3
    set_core[B_T0_OVF] = t0_ovf; // see RL3
    set_core[B_EXT_PIN_IRQ_FLAG] = ext_edge; // see RL4
    set_main[B_FUNCTION] = ev_bad_fetch | ev_bus_idle; // see RL5
    set_main[B_SUMMARY] = ev_ep0_out_nak | ev_ep0_in_nak | ev_ep1_in_nak | ev_ep2_in_nak
                          | ev_ep1_in_ack | ev_ep2_in_ack
                          | ev_ep0_rx_stall | ev_ep0_tx_stall; // see RL6
    set_main[B_EP0_OUT] = ev_ep0_out_done; // see RL7
    set_main[B_EP0_IN] = ev_ep0_in_done; // see RL8
    set_main[B_TOGGLE_ERR] = ev_ep0_toggle_err; // see RL9
    set_main[B_SETUP_OVW] = ovw_fire; // see RL10
    set_main[B_SETUP] = ev_setup_done; // see RL11
    set_hs[B_EP2_IN] = ev_ep2_in_done; // see RL12
    set_hs[B_EP1_IN] = ev_ep1_in_done; // see RL12
    set_hs[B_STALL_RX] = ev_ep0_rx_stall; // see RL13
    set_hs[B_STALL_TX] = ev_ep0_tx_stall; // see RL13
    set_hs[B_NAK_EP2_IN] = ev_ep2_in_nak; // see RL14
    set_hs[B_NAK_EP1_IN] = ev_ep1_in_nak; // see RL14
    set_hs[B_NAK_EP0_OUT] = ev_ep0_out_nak; // see RL14
    set_hs[B_NAK_EP0_IN] = ev_ep0_in_nak; // see RL14
    set_fun[B_BUS_IDLE] = ev_bus_idle; // see RL15
    set_fun[B_BAD_FETCH] = ev_bad_fetch; // see RL16
  end

  // flag registers: set wins over write-zero and service clears in the same cycle
  logic [7:0] next_core; // next core flags
  logic [7:0] next_main; // next main flags
  logic [7:0] next_hs; // next handshake flags
  logic [7:0] next_fun; // next function flags
  always_comb
  begin
    next_core = ((irq_flags_core & ~w0_mask(wr_now, addr_idx, IDX_FLAGS_CORE, wbyte)
                 & ~(ack_core & HWCLR_CORE)) | set_core) & MASK_CORE; // see RL24
    next_main = ((irq_flags_usb_main & ~w0_mask(wr_now, addr_idx, IDX_FLAGS_MAIN, wbyte)
                 & ~(ack_main & HWCLR_MAIN)) | set_main) & MASK_MAIN; // see RL24
    next_hs = ((irq_flags_usb_handshake & ~w0_mask(wr_now, addr_idx, IDX_FLAGS_HS, wbyte))
               | set_hs) & MASK_HS; // see RL2
    next_fun = ((irq_flags_usb_function & ~w0_mask(wr_now, addr_idx, IDX_FLAGS_FUN, wbyte))
                | set_fun) & MASK_FUN; // see RL2
  end

  // flag storage
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_flags_core <= ZERO_BYTE;
      irq_flags_usb_main <= ZERO_BYTE;
      irq_flags_usb_handshake <= ZERO_BYTE;
      irq_flags_usb_function <= ZERO_BYTE;
    end
    else if (usb_reset)
    begin
      irq_flags_core <= ZERO_BYTE; // see RL17
      irq_flags_usb_main <= ZERO_BYTE;
      irq_flags_usb_handshake <= ZERO_BYTE;
      irq_flags_usb_function <= ZERO_BYTE;
    end
    else
    begin
      irq_flags_core <= next_core;
      irq_flags_usb_main <= next_main;
      irq_flags_usb_handshake <= next_hs;
      irq_flags_usb_function <= next_fun;
    end
  end

  // read mux; preset offsets return the live count
  function automatic logic [7:0] read_mux(input logic [7:0] idx);
    if (idx == IDX_T0_PRESET)
      read_mux = t0_count; // see RL18
    else if (idx == IDX_T1_PRESET)
      read_mux = t1_count;
    else if (idx == IDX_TMR_CTRL)
      read_mux = timer_control;
    else if (idx == IDX_EXT_EDGE)
      read_mux = {7'h00, ext_edge_select};
    else if (idx == IDX_FLAGS_CORE)
      read_mux = irq_flags_core;
    else if (idx == IDX_FLAGS_MAIN)
      read_mux = irq_flags_usb_main;
    else if (idx == IDX_FLAGS_HS)
      read_mux = irq_flags_usb_handshake;
    else if (idx == IDX_FLAGS_FUN)
      read_mux = irq_flags_usb_function;
    else
      read_mux = ZERO_BYTE; // unmapped reads zero
  endfunction : read_mux

  // read data sampled in the wait cycle, after any prior write landed
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      hrdata <= 32'h00000000;
    else if (state == BUS_RWAIT)
      hrdata <= {24'h000000, read_mux(addr_idx)};
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_TMR_OVF_FLAG: assert property ((t0_ovf || t1_ovf) && !usb_reset
    |=> (irq_flags_core[B_T0_OVF] || !$past(t0_ovf))
    && (irq_flags_core[B_T1_OVF] || !$past(t1_ovf))) // see RL3
    else $error("timer overflow did not set flags");
  AST_ACK_CLEAR: assert property (ack_core[B_CAPTURE] && !ev_capture_done
    |=> !irq_flags_core[B_CAPTURE]) // see RL1
    else $error("service ack did not clear capture flag");
  AST_ACK_MAIN: assert property (ack_main[B_EP0_IN] && !ev_ep0_in_done
    |=> !irq_flags_usb_main[B_EP0_IN]) // see RL24
    else $error("service ack did not clear ep0 in flag");
  AST_W0_CLEAR: assert property (wr_now && addr_idx == IDX_FLAGS_HS && !wbyte[B_EP2_IN]
    && !ev_ep2_in_done |=> !irq_flags_usb_handshake[B_EP2_IN]) // see RL2
    else $error("write zero did not clear");
  AST_W1_KEEP: assert property (irq_flags_usb_handshake[B_EP1_IN] && !usb_reset
    |=> irq_flags_usb_handshake[B_EP1_IN] || $past(wr_now && !wbyte[B_EP1_IN])) // see RL12
    else $error("flag lost without write zero");
  AST_FUN_SW_ONLY: assert property (irq_flags_usb_main[B_FUNCTION] && !usb_reset
    && !(wr_now && addr_idx == IDX_FLAGS_MAIN) |=> irq_flags_usb_main[B_FUNCTION]) // see RL5
    else $error("function flag cleared by hardware");
  AST_EXT_EDGE: assert property (ext_edge && !usb_reset
    |=> irq_flags_core[B_EXT_PIN_IRQ_FLAG]) // see RL4
    else $error("pin edge did not set flag");
  AST_SUSPEND: assert property (ev_bus_idle && !usb_reset
    |=> irq_flags_usb_function[B_BUS_IDLE] && irq_flags_usb_main[B_FUNCTION]) // see RL15
    else $error("bus idle did not set flags");
  AST_SUMMARY: assert property ((ev_ep1_in_ack || ev_ep0_tx_stall) && !usb_reset
    |=> irq_flags_usb_main[B_SUMMARY]) // see RL6
    else $error("summary flag not set");
  AST_OVW_SEQ: assert property (ev_setup_overwrite && !usb_reset ##1
    ev_token_inout && !usb_reset |=> irq_flags_usb_main[B_SETUP_OVW]) // see RL10
    else $error("overwrite flag not set on token");
  AST_USB_RESET: assert property (usb_reset |=> irq_flags_core == ZERO_BYTE
    && irq_flags_usb_main == ZERO_BYTE && t0_count == ZERO_BYTE
    && t1_count == ZERO_BYTE && timer_control == ZERO_BYTE) // see RL17
    else $error("usb reset did not clear state");
  AST_READ_WAIT: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");

  COV_T0_WRAP: cover property (t0_ovf);
  COV_ACK_AND_SET: cover property (ack_core[B_EXT_PIN_IRQ_FLAG] && ext_edge);
  COV_READ_FLAGS: cover property (state == BUS_RWAIT && addr_idx == IDX_FLAGS_MAIN);
  COV_OVW: cover property (ovw_fire);
endmodule : irqbt_top

// File: irqbt_usb_model.sv
// behavioural usb engine that raises one event strobe on request
`timescale 1ns/10ps
module irqbt_usb_model (
  // clock
  input wire logic clk_sys,
  // request from the bench
  input wire logic [4:0] sel,
  input wire logic fire,
  // event strobes toward the flag block
  output logic [18:0] ev
);
  // quiet before the first edge so the flag block never sees an unknown
  initial ev = 19'h0;
  // one cycle high and never two events at once, like the engine's own strobes
  always @(posedge clk_sys)
  begin
    ev <= fire ? (19'h1 << sel) : 19'h0;
  end
endmodule : irqbt_usb_model

// File: testbench.sv
// self-checking bench for the flag registers and base timers
`timescale 1ns/10ps
module testbench;
  import irqbt_pkg::*;
  // bus master and cpu side
  logic clk_sys = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, usb_reset = 1'b0;
  logic ext_irq_pin = 1'b1, fire = 1'b0, hreadyout, hresp, rdy_s;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_s, flags, e;
  logic [1:0] htrans = 2'h0;
  logic [7:0] ack_core = 8'h00, ack_main = 8'h00, fc, fm, fh, ff, rd, p, d;
  logic [4:0] sel = 5'h00;
  logic [18:0] ev;
  int bad_count = 0, tests_run = 0, c, n;
  // flag register addresses: core, main, handshake, function
  localparam logic [31:0] FA [4] = '{32'h368, 32'h36C, 32'h378, 32'h37C};
  // flags each engine event must raise, packed {function, handshake, main, core}
  localparam logic [31:0] EXP [17] = '{32'h10, 32'h1000, 32'h800, 32'h400,
    32'h100, 32'h400000, 32'h800000, 32'h202000, 32'h102000, 32'h82000,
    32'h42000, 32'h22000, 32'h12000, 32'h2000, 32'h2000, 32'h4004000, 32'h2004000};
  assign flags = {ff, fh, fm, fc};
  initial forever #5 clk_sys = ~clk_sys;
  // ready and data seen just before each rising edge, free of edge races
  always @(negedge clk_sys)
  begin
    rdy_s = hreadyout;
    rd_s = hrdata;
  end
  irqbt_usb_model mdl (.clk_sys(clk_sys), .sel(sel), .fire(fire), .ev(ev));
  irqbt_top uut (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .usb_reset(usb_reset),
    .ev_capture_done(ev[0]), .ev_ep0_out_done(ev[1]), .ev_ep0_in_done(ev[2]),
    .ev_ep0_toggle_err(ev[3]), .ev_setup_done(ev[4]), .ev_ep1_in_done(ev[5]),
    .ev_ep2_in_done(ev[6]), .ev_ep0_rx_stall(ev[7]), .ev_ep0_tx_stall(ev[8]),
    .ev_ep2_in_nak(ev[9]), .ev_ep1_in_nak(ev[10]), .ev_ep0_out_nak(ev[11]),
    .ev_ep0_in_nak(ev[12]), .ev_ep1_in_ack(ev[13]), .ev_ep2_in_ack(ev[14]),
    .ev_bus_idle(ev[15]), .ev_bad_fetch(ev[16]), .ev_setup_overwrite(ev[17]),
    .ev_token_inout(ev[18]), .ext_irq_pin(ext_irq_pin), .ack_core(ack_core),
    .ack_main(ack_main), .irq_flags_core(fc), .irq_flags_usb_main(fm),
    .irq_flags_usb_handshake(fh), .irq_flags_usb_function(ff));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  // one ahb-lite single transfer; holds each phase until ready is sampled high
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys); while (rdy_s !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk_sys); while (rdy_s !== 1'b1);
    rd = rd_s[7:0];
    chk("okay response", hresp, 1'b0);
  endtask : bus
  // flag levels looked at mid-cycle, then back on the rising edge
  task automatic look(input string nm, input logic [31:0] x);
    @(negedge clk_sys);
    chk(nm, flags, x);
    @(posedge clk_sys);
  endtask : look
  // ask the engine model for one event strobe
  task automatic pulse(input int i);
    sel <= i[4:0];
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : pulse
  task automatic clr;
    usb_reset <= 1'b1;
    @(posedge clk_sys);
    usb_reset <= 1'b0;
    @(posedge clk_sys);
  endtask : clr
  // service clears only the hardware-clearable flags
  function automatic logic [31:0] after_ack(input logic [31:0] v);
    return v & ~{16'h0, HWCLR_MAIN, HWCLR_CORE};
  endfunction : after_ack
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // watchdog, far beyond the roughly nine hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(90747));
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int r = 0; r < 4; r++)
    begin
      bus(1'b0, FA[r], 8'h00);
      chk("reset flags", rd, 8'h00);
    end
    bus(1'b0, 32'h348, 8'h00);
    chk("reset count", rd, 8'h00);
    bus(1'b1, 32'h100, 8'hFF);
    bus(1'b0, 32'h100, 8'h00);
    chk("unmapped read", rd, 8'h00);
    // every engine event but setup overwrite and token: set, read back, service, random software write, reset
    for (int i = 0; i < 17; i++)
    begin
      pulse(i);
      e = EXP[i];
      look("event", e);
      for (int r = 0; r < 4; r++)
      begin
        bus(1'b0, FA[r], 8'h00);
        chk("flag read", rd, e[r*8 +: 8]);
      end
      ack_core <= 8'hFF;
      ack_main <= 8'hFF;
      @(posedge clk_sys);
      ack_core <= 8'h00;
      ack_main <= 8'h00;
      e = after_ack(e);
      look("service", e);
      for (int r = 0; r < 4; r++)
      begin
        d = 8'($urandom);
        bus(1'b1, FA[r], d);
        e[r*8 +: 8] = e[r*8 +: 8] & d;
      end
      look("write", e);
      clr();
      look("usb reset", 32'h0);
    end
    // setup overwrite needs the latch and a later token
    pulse(18);
    look("token alone", 32'h0);
    pulse(17);
    look("overwrite noted", 32'h0);
    pulse(18);
    look("overwrite flag", 32'h200);
    // overwrite and token on consecutive cycles
    bus(1'b1, FA[1], 8'h00);
    sel <= 5'h11;
    fire <= 1'b1;
    @(posedge clk_sys);
    sel <= 5'h12;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (2) @(posedge clk_sys);
    look("back to back token", 32'h200);
    // external pin edges, both polarities
    ext_irq_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    look("falling edge", 32'h201);
    bus(1'b1, FA[0], 8'h00);
    bus(1'b1, 32'h2F4, 8'h01);
    ext_irq_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    look("rising edge", 32'h201);
    bus(1'b1, FA[0], 8'h00);
    ext_irq_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    look("falling ignored", 32'h200);
    // each timer from a preset to overflow, timer one at prescale one
    for (int t = 0; t < 2; t++)
    begin
      p = t ? 8'hFC : 8'hF0;
      n = ((256 - int'(p)) * BASE_DIV) << t;
      clr();
      bus(1'b1, 32'h348 + 4 * t, p);
      bus(1'b1, 32'h350, t ? 8'h90 : 8'h08);
      c = 0;
      do
      begin
        @(negedge clk_sys);
        c++;
      end while (fc[t ? 3 : 1] !== 1'b1 && c < 2 * n);
      @(posedge clk_sys);
      chk("overflow time", c > n - 16 && c < n + 16, 1);
      bus(1'b0, 32'h348 + 4 * t, 8'h00);
      chk("reloaded count", rd >= p, 1);
    end
    report_and_stop();
  end
endmodule : testbench
